// *** rtl/hwtr_tuning_regs.sv ***
`default_nettype none
module hwtr_tuning_regs
  import hwtr_pkg::*;
#(
  parameter logic [6:0] DEV_ADDR   = HWTR_I2C_ADDR_DFLT,
  parameter int         CYC_PER_MS = HWTR_CYC_PER_MS
) (
  input  wire logic        clk,
  input  wire logic        resetn,
  input  wire logic        scl_in,
  input  wire logic        sda_in,
  output logic             sda_out,
  output logic             sda_oe,
  input  wire logic        closed_loop,
  input  wire logic [7:0]  waveform_step_period,
  input  wire logic [7:0]  wave_max_level,
  input  wire logic [7:0]  wave_min_level,
  input  wire logic        seg_valid,
  input  wire logic [7:0]  seg_level,
  input  wire logic [7:0]  seg_steps,
  output logic             seg_ready,
  input  wire logic        brake_settled,
  output logic             drive_active,
  output logic [7:0]       drive_level,
  output hwtr_seg_kind_t   drive_kind,
  output logic [7:0]       fb_gain,
  output logic [7:0]       loss_comp,
  input  wire logic        cal_start,
  input  wire logic        cal_meas_valid,
  input  wire logic [7:0]  cal_impedance,
  input  wire logic [7:0]  cal_bemf,
  output logic             cal_busy,
  output logic             cal_done
);
  // the ms divider needs at least one clock per millisecond
  if (CYC_PER_MS < 1) begin : g_cyc_check
    $error("CYC_PER_MS must be at least 1");
  end
  // 0000xxx and 1111xxx are reserved bus addresses
  if (DEV_ADDR[6:3] == 4'h0 || DEV_ADDR[6:3] == 4'hf) begin : g_addr_check
    $error("DEV_ADDR lies in a reserved address range");
  end

  typedef enum logic [1:0] {
    HWTR_M_IDLE,
    HWTR_M_PLAY,
    HWTR_M_CBRAKE
  } hwtr_mode_t;

  typedef struct packed {
    logic [7:0]     neg_sus;
    logic [7:0]     brk_off;
    logic [7:0]     full_scale;
    logic [7:0]     od_limit;
    logic [7:0]     comp;
    logic [7:0]     fbg;
    hwtr_mode_t     mode;
    logic           active;
    logic [7:0]     level;
    hwtr_seg_kind_t kind;
    logic           cal_busy;
    logic           cal_done;
  } hwtr_state_t;

  // one register image for the bank, the player and calibration
  hwtr_state_t s_r;
  hwtr_state_t s_nxt;

  // strobes and pointer from the serial port
  logic        wr_en;
  logic [7:0]  wr_addr;
  logic [7:0]  wr_data;
  logic [7:0]  rd_addr;
  logic [7:0]  rd_data;
  logic        tmr_start;
  logic [8:0]  tmr_steps;
  logic        tmr_busy;
  logic        tmr_done;

  // serial register port; writes arrive as one-cycle strobes
  hwtr_i2c_slave #(
    .DEV_ADDR (DEV_ADDR)
  ) u_i2c (
    .clk     (clk),
    .resetn  (resetn),
    .scl_in  (scl_in),
    .sda_in  (sda_in),
    .sda_oe  (sda_oe),
    .wr_en   (wr_en),
    .wr_addr (wr_addr),
    .wr_data (wr_data),
    .rd_addr (rd_addr),
    .rd_data (rd_data)
  );

  // segment length in clocks: steps times period times CYC_PER_MS
  hwtr_seg_timer #(
    .CYC_PER_MS (CYC_PER_MS)
  ) u_tmr (
    .clk       (clk),
    .resetn    (resetn),
    .start     (tmr_start),
    .steps     (tmr_steps),
    .period_ms (waveform_step_period),
    .busy      (tmr_busy),
    .done      (tmr_done)
  );

  // register read mux
  // gaps read as zero so a probe of an unused offset is harmless
  always_comb begin
    if (rd_addr == HWTR_NEG_SUSTAIN_TIME_OFFSET_ADDR) begin
      rd_data = s_r.neg_sus;
    end else if (rd_addr == HWTR_BRAKE_TIME_OFFSET_ADDR) begin
      rd_data = s_r.brk_off;
    end else if (rd_addr == HWTR_MOTOR_FULL_SCALE_LEVEL_ADDR) begin
      rd_data = s_r.full_scale;
    end else if (rd_addr == HWTR_OVERDRIVE_LIMIT_ADDR) begin
      rd_data = s_r.od_limit;
    end else if (rd_addr == HWTR_LOSS_COMPENSATION_ADDR) begin
      rd_data = s_r.comp;
    end else if (rd_addr == HWTR_FEEDBACK_GAIN_CAL_ADDR) begin
      rd_data = s_r.fbg;
    end else begin
      rd_data = HWTR_UNMAPPED_READ;
    end
  end

  // segment classification from the waveform extremes
  hwtr_seg_kind_t seg_kind;
  logic signed [9:0] seg_len;
  logic signed [9:0] seg_off;
  logic [8:0]        lim;
  logic signed [9:0] lvl_s;
  logic signed [9:0] lim_s;
  logic [7:0]        lvl_clamped;
  logic              cl_brake;

  // overdrive must be positive and brake negative, so a level that is
  // both extremes of a flat waveform still has exactly one kind
  always_comb begin
    if (seg_level == wave_max_level && !seg_level[7]) begin
      seg_kind = HWTR_SEG_OVERDRIVE;
    end else if (seg_level == wave_min_level && seg_level[7]) begin
      seg_kind = HWTR_SEG_BRAKE;
    end else if (seg_level[7]) begin
      seg_kind = HWTR_SEG_NEG_SUSTAIN;
    end else begin
      seg_kind = HWTR_SEG_POS_SUSTAIN;
    end
  end

  // signed offset added to the nominal step count
  always_comb begin
    seg_off = '0;
    if (seg_kind == HWTR_SEG_NEG_SUSTAIN) begin
      seg_off = {{2{s_r.neg_sus[7]}}, s_r.neg_sus};
    end else if (seg_kind == HWTR_SEG_BRAKE && !closed_loop) begin
      seg_off = {{2{s_r.brk_off[7]}}, s_r.brk_off};
    end
    seg_len = $signed({2'b00, seg_steps}) + seg_off;
    // a shortening below zero leaves an empty segment, not a wrapped one
    if (seg_len[9]) begin
      tmr_steps = 9'h000;
    end else begin
      tmr_steps = seg_len[8:0];
    end
  end

  // magnitude limit, same for both polarities
  always_comb begin
    lvl_s = {{2{seg_level[7]}}, seg_level};
    if (seg_kind == HWTR_SEG_OVERDRIVE || seg_kind == HWTR_SEG_BRAKE) begin
      lim = {1'b0, s_r.od_limit};
    end else begin
      lim = {1'b0, s_r.full_scale};
    end
    lim_s = $signed({1'b0, lim});
    lvl_clamped = seg_level;
    if (closed_loop) begin
      // saturate: limits above 127 do not fit a signed byte
      if (lvl_s > lim_s) begin
        lvl_clamped = (lim > 9'h07f) ? 8'h7f : lim[7:0];
      end else if (lvl_s < -lim_s) begin
        lvl_clamped = (lim > 9'h080) ? 8'h80 : 8'(-lim_s);
      end
    end
  end

  // closed-loop braking ends on feedback, so the timer stays idle
  assign cl_brake  = closed_loop && seg_kind == HWTR_SEG_BRAKE;
  assign seg_ready = (s_r.mode == HWTR_M_IDLE);
  assign tmr_start = seg_valid && seg_ready && !cl_brake;

  always_comb begin
    s_nxt = s_r;
    s_nxt.cal_done = 1'b0;
    // host writes
    if (wr_en) begin
      if (wr_addr == HWTR_NEG_SUSTAIN_TIME_OFFSET_ADDR) begin
        s_nxt.neg_sus = wr_data;
      end else if (wr_addr == HWTR_BRAKE_TIME_OFFSET_ADDR) begin
        s_nxt.brk_off = wr_data;
      end else if (wr_addr == HWTR_MOTOR_FULL_SCALE_LEVEL_ADDR) begin
        s_nxt.full_scale = wr_data;
      end else if (wr_addr == HWTR_OVERDRIVE_LIMIT_ADDR) begin
        s_nxt.od_limit = wr_data;
      end else if (wr_addr == HWTR_LOSS_COMPENSATION_ADDR) begin
        s_nxt.comp = wr_data;
      end else if (wr_addr == HWTR_FEEDBACK_GAIN_CAL_ADDR) begin
        s_nxt.fbg = wr_data;
      end
    end
    // calibration result overrides a host write in the same cycle
    // a start while busy is ignored
    if (cal_start && !s_r.cal_busy) begin
      s_nxt.cal_busy = 1'b1;
    end else if (s_r.cal_busy && cal_meas_valid) begin
      s_nxt.cal_busy = 1'b0;
      s_nxt.cal_done = 1'b1;
      s_nxt.comp     = cal_impedance >> HWTR_COMP_SHIFT;
      s_nxt.fbg      = cal_bemf;
    end
    // playback
    case (s_r.mode)
      HWTR_M_IDLE: begin
        // level drops to zero between segments so the driver idles
        s_nxt.active = 1'b0;
        s_nxt.level  = 8'h00;
        if (seg_valid) begin
          s_nxt.kind   = seg_kind;
          s_nxt.level  = lvl_clamped;
          s_nxt.active = 1'b1;
          if (cl_brake) begin
            s_nxt.mode = HWTR_M_CBRAKE;
          end else begin
            s_nxt.mode = HWTR_M_PLAY;
          end
        end
      end
      HWTR_M_PLAY: begin
        // an empty segment never sets busy, so idle also ends it
        if (tmr_done || !tmr_busy) begin
          s_nxt.mode   = HWTR_M_IDLE;
          s_nxt.active = 1'b0;
          s_nxt.level  = 8'h00;
        end
      end
      HWTR_M_CBRAKE: begin
        // brake offset plays no part here
        if (brake_settled) begin
          s_nxt.mode   = HWTR_M_IDLE;
          s_nxt.active = 1'b0;
          s_nxt.level  = 8'h00;
        end
      end
      default: begin
        s_nxt.mode = HWTR_M_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      // clear the image, then load the register defaults
      s_r            <= '0;
      s_r.neg_sus    <= HWTR_NEG_SUSTAIN_RST;
      s_r.brk_off    <= HWTR_BRAKE_OFFSET_RST;
      s_r.full_scale <= HWTR_FULL_SCALE_RST;
      s_r.od_limit   <= HWTR_OD_LIMIT_RST;
      s_r.comp       <= HWTR_LOSS_COMP_RST;
      s_r.fbg        <= HWTR_FB_GAIN_RST;
      s_r.mode       <= HWTR_M_IDLE;
      s_r.kind       <= HWTR_SEG_POS_SUSTAIN;
    end else begin
      s_r <= s_nxt;
    end
  end

  // open drain: the pin only ever pulls low
  assign sda_out      = 1'b0;
  assign drive_active = s_r.active;
  assign drive_level  = s_r.level;
  assign drive_kind   = s_r.kind;
  assign fb_gain      = s_r.fbg;
  assign loss_comp    = s_r.comp;
  assign cal_busy     = s_r.cal_busy;
  assign cal_done     = s_r.cal_done;
endmodule
`default_nettype wire

// *** rtl/hwtr_pkg.sv ***
`default_nettype none
package hwtr_pkg;
  // register offsets
  localparam logic [7:0] HWTR_NEG_SUSTAIN_TIME_OFFSET_ADDR = 8'h1c;
  localparam logic [7:0] HWTR_BRAKE_TIME_OFFSET_ADDR       = 8'h1d;
  localparam logic [7:0] HWTR_MOTOR_FULL_SCALE_LEVEL_ADDR  = 8'h1f;
  localparam logic [7:0] HWTR_OVERDRIVE_LIMIT_ADDR         = 8'h20;
  localparam logic [7:0] HWTR_LOSS_COMPENSATION_ADDR       = 8'h21;
  localparam logic [7:0] HWTR_FEEDBACK_GAIN_CAL_ADDR       = 8'h22;

  // values after reset
  localparam logic [7:0] HWTR_NEG_SUSTAIN_RST  = 8'h00;
  localparam logic [7:0] HWTR_BRAKE_OFFSET_RST = 8'h00;
  localparam logic [7:0] HWTR_FULL_SCALE_RST   = 8'h3f;
  localparam logic [7:0] HWTR_OD_LIMIT_RST     = 8'h89;
  localparam logic [7:0] HWTR_LOSS_COMP_RST    = 8'h0d;
  localparam logic [7:0] HWTR_FB_GAIN_RST      = 8'h6d;
  localparam logic [7:0] HWTR_UNMAPPED_READ    = 8'h00;

  // bus address of the device, arbitrary value
  localparam logic [6:0] HWTR_I2C_ADDR_DFLT = 7'h2a;

  // timing
  localparam int HWTR_CLK_PERIOD_NS = 20;
  localparam int HWTR_MS_NS         = 1000000;
  localparam int HWTR_CYC_PER_MS    = HWTR_MS_NS / HWTR_CLK_PERIOD_NS;

  // compensation derived from impedance by a right shift
  localparam int HWTR_COMP_SHIFT = 2;

  typedef enum logic [1:0] {
    HWTR_SEG_POS_SUSTAIN,
    HWTR_SEG_OVERDRIVE,
    HWTR_SEG_NEG_SUSTAIN,
    HWTR_SEG_BRAKE
  } hwtr_seg_kind_t;
endpackage
`default_nettype wire

// *** rtl/hwtr_i2c_slave.sv ***
`default_nettype none
module hwtr_i2c_slave
  import hwtr_pkg::*;
#(
  parameter logic [6:0] DEV_ADDR = HWTR_I2C_ADDR_DFLT
) (
  input  wire logic       clk,
  input  wire logic       resetn,
  input  wire logic       scl_in,
  input  wire logic       sda_in,
  output logic            sda_oe,
  output logic            wr_en,
  output logic [7:0]      wr_addr,
  output logic [7:0]      wr_data,
  output logic [7:0]      rd_addr,
  input  wire logic [7:0] rd_data
);
  typedef enum logic [2:0] {
    I_IDLE, I_ADDR, I_AACK, I_WBYTE, I_WACK, I_RBYTE, I_RACK
  } hwtr_i2c_st_t;

  typedef struct packed {
    hwtr_i2c_st_t st;
    logic [7:0]   sh;
    logic [3:0]   cnt;
    logic         rw;
    logic         first;
    logic [7:0]   ptr;
    logic         oe;
    logic         scl_q;
    logic         sda_q;
    logic         wr;
    logic [7:0]   waddr;
    logic [7:0]   wdata;
  } hwtr_i2c_t;

  hwtr_i2c_t s_r, s_nxt;
  logic rise, fall, start_c, stop_c;

  always_comb begin
    s_nxt   = s_r;
    rise    = scl_in & ~s_r.scl_q;
    fall    = ~scl_in & s_r.scl_q;
    start_c = scl_in & s_r.scl_q & s_r.sda_q & ~sda_in;
    stop_c  = scl_in & s_r.scl_q & ~s_r.sda_q & sda_in;
    s_nxt.scl_q = scl_in;
    s_nxt.sda_q = sda_in;
    s_nxt.wr    = 1'b0;
    if (start_c) begin
      s_nxt.st  = I_ADDR;
      s_nxt.cnt = 4'h0;
      s_nxt.oe  = 1'b0;
    end else if (stop_c) begin
      s_nxt.st = I_IDLE;
      s_nxt.oe = 1'b0;
    end else if (rise) begin
      case (s_r.st)
        I_ADDR, I_WBYTE: begin
          s_nxt.sh  = {s_r.sh[6:0], sda_in};
          s_nxt.cnt = s_r.cnt + 4'h1;
        end
        I_RACK: begin
          if (sda_in) begin
            s_nxt.st = I_IDLE;
          end
        end
        default: begin
        end
      endcase
    end else if (fall) begin
      case (s_r.st)
        I_ADDR: begin
          if (s_r.cnt == 4'h8) begin
            if (s_r.sh[7:1] == DEV_ADDR) begin
              s_nxt.oe = 1'b1;
              s_nxt.rw = s_r.sh[0];
              s_nxt.st = I_AACK;
            end else begin
              s_nxt.st = I_IDLE;
            end
          end
        end
        I_AACK: begin
          s_nxt.cnt = (s_r.rw) ? 4'h1 : 4'h0;
          if (s_r.rw) begin
            s_nxt.sh = rd_data;
            s_nxt.oe = ~rd_data[7];
            s_nxt.st = I_RBYTE;
          end else begin
            s_nxt.oe    = 1'b0;
            s_nxt.first = 1'b1;
            s_nxt.st    = I_WBYTE;
          end
        end
        I_WBYTE: begin
          if (s_r.cnt == 4'h8) begin
            s_nxt.oe = 1'b1;
            s_nxt.st = I_WACK;
            if (s_r.first) begin
              s_nxt.ptr = s_r.sh;
            end else begin
              s_nxt.wr    = 1'b1;
              s_nxt.waddr = s_r.ptr;
              s_nxt.wdata = s_r.sh;
              s_nxt.ptr   = s_r.ptr + 8'h01;
            end
          end
        end
        I_WACK: begin
          s_nxt.oe    = 1'b0;
          s_nxt.first = 1'b0;
          s_nxt.cnt   = 4'h0;
          s_nxt.st    = I_WBYTE;
        end
        I_RBYTE: begin
          if (s_r.cnt == 4'h8) begin
            s_nxt.oe  = 1'b0;
            s_nxt.ptr = s_r.ptr + 8'h01;
            s_nxt.st  = I_RACK;
          end else begin
            s_nxt.sh  = {s_r.sh[6:0], 1'b0};
            s_nxt.oe  = ~s_r.sh[6];
            s_nxt.cnt = s_r.cnt + 4'h1;
          end
        end
        I_RACK: begin
          s_nxt.sh  = rd_data;
          s_nxt.oe  = ~rd_data[7];
          s_nxt.cnt = 4'h1;
          s_nxt.st  = I_RBYTE;
        end
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      s_r       <= '0;
      s_r.st    <= I_IDLE;
      s_r.scl_q <= 1'b1;
      s_r.sda_q <= 1'b1;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign sda_oe  = s_r.oe;
  assign wr_en   = s_r.wr;
  assign wr_addr = s_r.waddr;
  assign wr_data = s_r.wdata;
  assign rd_addr = s_r.ptr;
endmodule
`default_nettype wire

// *** rtl/hwtr_seg_timer.sv ***
`default_nettype none
module hwtr_seg_timer
  import hwtr_pkg::*;
#(
  parameter int CYC_PER_MS = HWTR_CYC_PER_MS
) (
  input  wire logic       clk,
  input  wire logic       resetn,
  input  wire logic       start,
  input  wire logic [8:0] steps,
  input  wire logic [7:0] period_ms,
  output logic            busy,
  output logic            done
);
  localparam int CW = $clog2(CYC_PER_MS + 1);
  localparam logic [CW-1:0] CYC_LAST = CW'(CYC_PER_MS - 1);

  if (CYC_PER_MS < 1) begin : g_cyc_check
    $error("CYC_PER_MS must be at least 1");
  end

  typedef struct packed {
    logic          busy;
    logic          done;
    logic [8:0]    step_left;
    logic [7:0]    ms_left;
    logic [CW-1:0] cyc;
  } hwtr_tmr_t;

  hwtr_tmr_t t_r, t_nxt;

  // length in ms is steps times the step period
  always_comb begin
    t_nxt      = t_r;
    t_nxt.done = 1'b0;
    if (start) begin
      t_nxt.cyc = '0;
      if (steps == 9'h000 || period_ms == 8'h00) begin
        t_nxt.busy = 1'b0;
        t_nxt.done = 1'b1;
      end else begin
        t_nxt.busy      = 1'b1;
        t_nxt.step_left = steps;
        t_nxt.ms_left   = period_ms;
      end
    end else if (t_r.busy) begin
      if (t_r.cyc == CYC_LAST) begin
        t_nxt.cyc = '0;
        if (t_r.ms_left == 8'h01) begin
          t_nxt.ms_left = period_ms;
          if (t_r.step_left == 9'h001) begin
            t_nxt.busy = 1'b0;
            t_nxt.done = 1'b1;
          end else begin
            t_nxt.step_left = t_r.step_left - 9'h001;
          end
        end else begin
          t_nxt.ms_left = t_r.ms_left - 8'h01;
        end
      end else begin
        t_nxt.cyc = t_r.cyc + CW'(1);
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      t_r <= '0;
    end else begin
      t_r <= t_nxt;
    end
  end

  assign busy = t_r.busy;
  assign done = t_r.done;
endmodule
`default_nettype wire

// *** bench/hwtr_tuning_regs_assertions.sv ***
`default_nettype none
module hwtr_tuning_regs_checker
  import hwtr_pkg::*;
(
  input wire logic           clk,
  input wire logic           resetn,
  input wire logic           closed_loop,
  input wire logic [7:0]     wave_min_level,
  input wire logic           seg_valid,
  input wire logic [7:0]     seg_level,
  input wire logic           seg_ready,
  input wire logic           brake_settled,
  input wire logic           drive_active,
  input wire logic [7:0]     drive_level,
  input wire hwtr_seg_kind_t drive_kind,
  input wire logic [7:0]     fb_gain,
  input wire logic [7:0]     loss_comp,
  input wire logic           cal_start,
  input wire logic           cal_meas_valid,
  input wire logic [7:0]     cal_impedance,
  input wire logic [7:0]     cal_bemf,
  input wire logic           cal_busy,
  input wire logic           cal_done
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  wire logic take = seg_valid && seg_ready;
  wire logic neg  = seg_level[7];
  wire logic hit  = cal_busy && cal_meas_valid;

  chk_seg_take: assert property (take |=> drive_active && !seg_ready)
    else $error("segment not taken");
  chk_open_level: assert property (
    take && !closed_loop |=> drive_level == $past(seg_level))
    else $error("open loop level altered");
  chk_brake_kind: assert property (
    take && neg && seg_level == wave_min_level
    |=> drive_kind == HWTR_SEG_BRAKE)
    else $error("brake not classified");
  chk_neg_kind: assert property (
    take && neg && seg_level != wave_min_level
    |=> drive_kind == HWTR_SEG_NEG_SUSTAIN)
    else $error("neg sustain not classified");
  chk_cl_brake: assert property (
    drive_active && closed_loop && drive_kind == HWTR_SEG_BRAKE
    && !brake_settled |=> drive_active)
    else $error("closed loop brake ended early");
  chk_cal_start: assert property (cal_start && !cal_busy |=> cal_busy)
    else $error("calibration not started");
  chk_comp_result: assert property (
    hit |=> cal_done && !cal_busy && loss_comp == $past(cal_impedance) >> 2)
    else $error("compensation result wrong");
  chk_gain_result: assert property (hit |=> fb_gain == $past(cal_bemf))
    else $error("feedback result wrong");
  chk_done_pulse: assert property (cal_done |=> !cal_done)
    else $error("done longer than one cycle");
  chk_reset_dflt: assert property (
    $rose(resetn) |-> fb_gain == HWTR_FB_GAIN_RST
    && loss_comp == HWTR_LOSS_COMP_RST)
    else $error("reset outputs wrong");

  cov_open: cover property (take && !closed_loop);
  cov_cl_brake: cover property (take && closed_loop && neg);
  cov_cal: cover property (cal_done);
endmodule

bind hwtr_tuning_regs hwtr_tuning_regs_checker i_chk (
  .clk, .resetn, .closed_loop, .wave_min_level, .seg_valid, .seg_level,
  .seg_ready, .brake_settled, .drive_active, .drive_level, .drive_kind,
  .fb_gain, .loss_comp, .cal_start, .cal_meas_valid, .cal_impedance,
  .cal_bemf, .cal_busy, .cal_done);
`default_nettype wire

// *** bench/hwtr_host_model.sv ***
`default_nettype none
module hwtr_host_model
  import hwtr_pkg::*;
(
  input  wire logic clk,
  input  wire logic sda_oe,
  output var  logic scl,
  output logic      sda
);
  timeunit 1ns;
  timeprecision 1ns;
  logic sda_m = 1'b1;
  initial scl = 1'b1;
  // pull-up: released line reads high
  assign sda = sda_m & !sda_oe;

  task automatic wt(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic bitx(input logic b, output logic r);
    wt(1);
    sda_m <= b;
    wt(3);
    scl <= 1'b1;
    wt(4);
    r = sda;
    scl <= 1'b0;
  endtask
  // a=1 start or repeated start, a=0 stop
  task automatic frame(input logic a);
    wt(1);
    sda_m <= a;
    wt(3);
    scl <= 1'b1;
    wt(4);
    sda_m <= !a;
    wt(4);
    if (a)
      scl <= 1'b0;
  endtask
  task automatic byte_x(input logic [7:0] d, output logic [7:0] q,
                        output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bitx(d[i], r);
      q[i] = r;
    end
    bitx(1'b1, r);
    ack = !r;
  endtask
  task automatic xfer(input logic [6:0] dev, input logic [7:0] a, d,
                      input logic rd, output logic [7:0] q,
                      output logic ok);
    logic a1, a2, a3, x;
    frame(1'b1);
    byte_x({dev, 1'b0}, q, a1);
    byte_x(a, q, a2);
    if (rd) begin
      frame(1'b1);
      byte_x({dev, 1'b1}, q, a3);
      byte_x(8'hff, q, x);
    end else
      byte_x(d, q, a3);
    frame(1'b0);
    ok = a1 & a2 & a3;
  endtask
endmodule
`default_nettype wire

// *** bench/test_hwtr_tuning_regs.sv ***
`default_nettype none
module test_hwtr_tuning_regs import hwtr_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int CPM = 4;
  logic           clk, resetn, closed_loop, seg_valid, brake_settled;
  logic           cal_start, cal_meas_valid, seg_ready, drive_active;
  logic           cal_busy, cal_done, scl, sda, sda_oe, ok, sda_drv;
  logic [7:0]     period, wmax, wmin, seg_level, seg_steps, drive_level;
  logic [7:0]     fb_gain, loss_comp, cal_imp, cal_bemf, lf, q;
  hwtr_seg_kind_t drive_kind;
  int             n_mismatch = 0, n_checks = 0, cyc = 0, base, d;
  logic [7:0]     ra [6] = '{8'h1c, 8'h1d, 8'h1f, 8'h20, 8'h21, 8'h22};
  logic [7:0]     rv [6] = '{8'h00, 8'h00, 8'h3f, 8'h89, 8'h0d, 8'h6d};
  logic [7:0]     offs [3] = '{8'h03, 8'hfd, 8'h81};
  logic [7:0]     lv [4] = '{8'h38, 8'h70, 8'hc0, 8'h90};

  hwtr_tuning_regs #(.CYC_PER_MS(CPM)) i_hwtr_tuning_regs (
    .clk, .resetn, .scl_in(scl), .sda_in(sda), .sda_out(sda_drv), .sda_oe,
    .closed_loop, .waveform_step_period(period), .wave_max_level(wmax),
    .wave_min_level(wmin), .seg_valid, .seg_level, .seg_steps, .seg_ready,
    .brake_settled, .drive_active, .drive_level, .drive_kind, .fb_gain,
    .loss_comp, .cal_start, .cal_meas_valid, .cal_impedance(cal_imp),
    .cal_bemf, .cal_busy, .cal_done);
  hwtr_host_model i_hwtr_host_model (.clk, .sda_oe, .scl, .sda);

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 80000) begin
      n_mismatch++;
      conclude();
    end
  end

  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction
  function automatic int seg_cyc(input int st, off);
    int s;
    s = st + off;
    return (s < 0 ? 0 : s) * int'(period) * CPM;
  endfunction
  function automatic logic [7:0] clamp(input logic [7:0] v, lim);
    int x;
    x = $signed(v);
    if (x > int'(lim))
      x = lim;
    if (x < -int'(lim))
      x = -int'(lim);
    return x[7:0];
  endfunction
  task automatic chk8(input logic [7:0] got, exp);
    n_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chkn(input int got, exp);
    n_checks++;
    if (got != exp) begin
      n_mismatch++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, v);
    i_hwtr_host_model.xfer(HWTR_I2C_ADDR_DFLT, a, v, 1'b0, q, ok);
  endtask
  task automatic rd_chk(input logic [7:0] a, exp);
    i_hwtr_host_model.xfer(HWTR_I2C_ADDR_DFLT, a, 8'h00, 1'b1, q, ok);
    chk8(q, exp);
  endtask
  task automatic play(input logic [7:0] l, st, output int n,
                      output logic [7:0] got);
    @(posedge clk);
    seg_valid <= 1'b1;
    seg_level <= l;
    seg_steps <= st;
    @(posedge clk);
    seg_valid <= 1'b0;
    #1 got = drive_level;
    n = 0;
    while (drive_active === 1'b1 && n < 3000) begin
      @(posedge clk);
      #1 n++;
    end
  endtask
  task automatic conclude();
    $display("checks=%0d mismatches=%0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  initial begin
    {resetn, closed_loop, seg_valid, cal_start, cal_meas_valid} = '0;
    brake_settled = 1'b1;
    period = 8'h02;
    wmax = 8'h70;
    wmin = 8'h90;
    {seg_level, seg_steps, cal_imp, cal_bemf} = '0;
    lf = 8'h25;
    repeat (10) @(posedge clk);
    resetn <= 1'b1;
    foreach (ra[i]) rd_chk(ra[i], rv[i]);
    i_hwtr_host_model.xfer(7'h15, 8'h1c, 8'h77, 1'b0, q, ok);
    chk8({6'h0, sda_drv, ok}, 8'h00);
    rd_chk(8'h1c, 8'h00);
    wr(8'h1e, 8'h5a);
    rd_chk(8'h1e, HWTR_UNMAPPED_READ);
    foreach (ra[i]) begin
      lf = lfsr(lf);
      wr(ra[i], lf);
      rd_chk(ra[i], lf);
    end
    play(8'h20, 8'd5, base, q);
    foreach (offs[k]) begin
      wr(8'h1c, offs[k]);
      wr(8'h1d, offs[k]);
      play(8'hc0, 8'd5, d, q);
      chkn(d - base, seg_cyc(5, $signed(offs[k])) - seg_cyc(5, 0));
      play(8'h90, 8'd5, d, q);
      chkn(d - base, seg_cyc(5, $signed(offs[k])) - seg_cyc(5, 0));
      play(8'h70, 8'd5, d, q);
      chkn(d, base);
    end
    wr(8'h1f, 8'h30);
    wr(8'h20, 8'h50);
    closed_loop <= 1'b1;
    foreach (lv[i]) begin
      play(lv[i], 8'd1, d, q);
      chk8(q, clamp(lv[i], i % 2 ? 8'h50 : 8'h30));
    end
    brake_settled <= 1'b0;
    fork
      play(8'h90, 8'd1, d, q);
      begin
        repeat (40) @(posedge clk);
        #1 chk8({7'h0, drive_active}, 8'h01);
        @(posedge clk);
        brake_settled <= 1'b1;
      end
    join
    for (int k = 0; k < 2; k++) begin
      lf = lfsr(lf);
      wr(8'h1f, lf);
      @(posedge clk);
      cal_start <= 1'b1;
      @(posedge clk);
      cal_start <= 1'b0;
      lf = lfsr(lf);
      cal_imp <= lf;
      cal_bemf <= ~lf;
      cal_meas_valid <= 1'b1;
      @(posedge clk);
      cal_meas_valid <= 1'b0;
      #1 chk8({7'h0, cal_done}, 8'h01);
      rd_chk(8'h21, lf >> 2);
      rd_chk(8'h22, ~lf);
    end
    conclude();
  end
endmodule
`default_nettype wire
